// ===== logic/dcf_cfg.svh
// Offsets, field positions, reset values and sizes for the status-flag FIFO.
`ifndef DCF_CFG_SVH
`define DCF_CFG_SVH

// ==========================================================================
// Buffer geometry and flag thresholds
// ==========================================================================
`define DCF_DEPTH_DEFAULT 64
`define DCF_DATA_W 8
`define DCF_AFULL_GAP 7
`define DCF_AEMPTY_LEVEL 8

// ==========================================================================
// Register map, byte addresses on the AXI4-Lite port
// ==========================================================================
`define DCF_ADDR_W 8
`define DCF_CTRL_OFFSET 8'h00
`define DCF_STATUS_OFFSET 8'h04
`define DCF_DEPTH_OFFSET 8'h08
`define DCF_CTRL_CLEAR_BIT 0
`define DCF_CTRL_RESET 1'b0
`define DCF_STATUS_FLAGS_LSB 0
`define DCF_STATUS_FILL_LSB 16
`define DCF_RESP_OKAY 2'b00
`define DCF_RESP_SLVERR 2'b10

// ==========================================================================
// Pin synchroniser reset image: wclk, rclk, wen_n, ren_n, oe_n, rst_n, data
// ==========================================================================
`define DCF_PIN_W 14
`define DCF_PIN_RST 14'h0E00

`endif

// ===== logic/dcf_pkg.sv
// Types shared by the status-flag FIFO design files.
package dcf_pkg;

    // ======================================================================
    // Pin bundle as it passes through the input synchroniser
    // ======================================================================
    typedef struct packed {
        logic wclk;
        logic rclk;
        logic wen_n;
        logic ren_n;
        logic oe_n;
        logic rst_n;
        logic [7:0] data;
    } dcf_pins_t;

    // ======================================================================
    // The four status flags, all active low
    // ======================================================================
    typedef struct packed {
        logic full_n;
        logic afull_n;
        logic aempty_n;
        logic empty_n;
    } dcf_flags_t;

endpackage : dcf_pkg

// ===== logic/dcf_sync.sv
// Two-stage synchroniser for a bundle of asynchronous input pins.
`timescale 1ns/1ps
`default_nettype none

module dcf_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // Raw pins and their synchronised copy.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ======================================================================
    // Per-bit double flop
    // ======================================================================
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta;
            // The first stage feeds only the second stage, never any logic.
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    meta <= RST_VAL[i];
                    sync_out[i] <= RST_VAL[i];
                end else begin
                    meta <= async_in[i];
                    sync_out[i] <= meta;
                end
            end
        end
    endgenerate

endmodule : dcf_sync

`default_nettype wire

// ===== logic/dcf_fifo.sv
// Eight-bit FIFO with clocked write and read ports, status flags and AXI4-Lite status.
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dcf_cfg.svh"

module dcf_fifo #(
    parameter int DEPTH = `DCF_DEPTH_DEFAULT
) (
    // System clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // Write port pins.
    input wire logic write_clk,
    input wire logic write_en_n,
    input wire logic [`DCF_DATA_W-1:0] write_data_in,
    // Read port pins.
    input wire logic read_clk,
    input wire logic read_en_n,
    input wire logic output_enable_n,
    output logic [`DCF_DATA_W-1:0] read_data_out,
    output logic read_data_oe,
    // Device reset pin.
    input wire logic reset_in_n,
    // Status flags.
    output logic full_flag_n,
    output logic almost_full_flag_n,
    output logic almost_empty_flag_n,
    output logic empty_flag_n,
    // AXI4-Lite write address channel.
    input wire logic [`DCF_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data channel.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response channel.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address channel.
    input wire logic [`DCF_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data channel.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ======================================================================
    // Geometry derived from the depth parameter
    // ======================================================================
    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;
    localparam logic [PW-1:0] FULL_LEVEL = PW'(DEPTH);
    localparam logic [PW-1:0] AFULL_LEVEL = PW'(DEPTH - `DCF_AFULL_GAP);
    localparam logic [PW-1:0] AEMPTY_LEVEL = PW'(`DCF_AEMPTY_LEVEL);
    localparam logic [PW-1:0] ONE = PW'(1);

    // ======================================================================
    // Pin synchronisation
    // ======================================================================
    dcf_pkg::dcf_pins_t pins_raw;
    dcf_pkg::dcf_pins_t pins;
    logic [`DCF_PIN_W-1:0] pins_sync;

    // All pins share one synchroniser so data stays aligned with its clock.
    assign pins_raw.wclk = write_clk;
    assign pins_raw.rclk = read_clk;
    assign pins_raw.wen_n = write_en_n;
    assign pins_raw.ren_n = read_en_n;
    assign pins_raw.oe_n = output_enable_n;
    assign pins_raw.rst_n = reset_in_n;
    assign pins_raw.data = write_data_in;
    assign pins = dcf_pkg::dcf_pins_t'(pins_sync);

    dcf_sync #(
        .WIDTH(`DCF_PIN_W),
        .RST_VAL(`DCF_PIN_RST)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    // ======================================================================
    // Clock edge detection
    // ======================================================================
    logic wclk_prev;
    logic rclk_prev;
    logic write_edge;
    logic read_edge;

    // Previous clock levels for rising-edge detection.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wclk_prev <= 1'b0;
            rclk_prev <= 1'b0;
        end else begin
            wclk_prev <= pins.wclk;
            rclk_prev <= pins.rclk;
        end
    end

    assign write_edge = pins.wclk & ~wclk_prev;
    assign read_edge = pins.rclk & ~rclk_prev;

    // ======================================================================
    // Control register and clear condition
    // ======================================================================
    logic ctrl_clear;
    logic clear_ptrs;

    // Both the device reset pin and the software clear empty the buffer.
    // The pin is sampled on the system clock, so free-running port clocks
    // during reset do no harm.
    assign clear_ptrs = ~pins.rst_n | ctrl_clear;

    // ======================================================================
    // Storage and pointers
    // ======================================================================
    logic [`DCF_DATA_W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] next_wr_ptr;
    logic [PW-1:0] next_rd_ptr;
    logic do_store;
    logic do_read;
    logic [PW-1:0] fill_after_store;
    logic [PW-1:0] fill_after_read;
    logic [PW-1:0] fill_now;

    // A store needs a write edge, enable low and the full flag high.
    assign do_store = write_edge & ~pins.wen_n & full_flag_n & ~clear_ptrs;
    // A read needs a read edge, enable low and the empty flag high.
    assign do_read = read_edge & ~pins.ren_n & empty_flag_n & ~clear_ptrs;
    assign next_wr_ptr = do_store ? wr_ptr + ONE : wr_ptr;
    assign next_rd_ptr = do_read ? rd_ptr + ONE : rd_ptr;
    // Each side measures against the other side's present pointer.
    assign fill_after_store = next_wr_ptr - rd_ptr;
    assign fill_after_read = wr_ptr - next_rd_ptr;
    assign fill_now = wr_ptr - rd_ptr;

    // Pointer registers; the extra top bit tells full from empty.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (clear_ptrs) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // The array has no reset; stale words are never read past the pointers.
    always_ff @(posedge sys_clk) begin
        if (do_store) begin
            mem[wr_ptr[AW-1:0]] <= pins.data;
        end
    end

    // ======================================================================
    // Write-side flags
    // ======================================================================
    // Updated only on write edges, so a read shortly before one shows up at
    // the next write edge rather than at once.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            full_flag_n <= 1'b1;
            almost_full_flag_n <= 1'b1;
        end else if (clear_ptrs) begin
            full_flag_n <= 1'b1;
            almost_full_flag_n <= 1'b1;
        end else if (write_edge) begin
            full_flag_n <= (fill_after_store != FULL_LEVEL);
            almost_full_flag_n <= (fill_after_store < AFULL_LEVEL);
        end
    end

    // ======================================================================
    // Read-side flags
    // ======================================================================
    // Updated only on read edges; a store just before a read edge may be
    // seen one read edge later, which bounds first-word latency to three.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            empty_flag_n <= 1'b0;
            almost_empty_flag_n <= 1'b0;
        end else if (clear_ptrs) begin
            empty_flag_n <= 1'b0;
            almost_empty_flag_n <= 1'b0;
        end else if (read_edge) begin
            empty_flag_n <= (fill_after_read != '0);
            almost_empty_flag_n <= (fill_after_read >= AEMPTY_LEVEL);
        end
    end

    // ======================================================================
    // Output register and drive enable
    // ======================================================================
    // The register is zero after any reset and holds when no read happens.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            read_data_out <= '0;
            read_data_oe <= 1'b0;
        end else begin
            read_data_oe <= ~pins.oe_n;
            if (clear_ptrs) begin
                read_data_out <= '0;
            end else if (do_read) begin
                read_data_out <= mem[rd_ptr[AW-1:0]];
            end
        end
    end

    // ======================================================================
    // AXI4-Lite write path
    // ======================================================================
    logic aw_hs;
    logic w_hs;
    logic b_hs;
    logic aw_held;
    logic w_held;
    logic [`DCF_ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [`DCF_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic do_write;
    logic wr_ctrl_hit;
    logic wr_mapped;

    // Address and data may arrive in either order; the live bus value is
    // used in the cycle it is taken so no extra cycle is lost.
    assign aw_hs = s_axi_awvalid & s_axi_awready;
    assign w_hs = s_axi_wvalid & s_axi_wready;
    assign b_hs = s_axi_bvalid & s_axi_bready;
    assign wr_addr = aw_held ? awaddr_q : s_axi_awaddr;
    assign wr_data = w_held ? wdata_q : s_axi_wdata;
    assign wr_strb = w_held ? wstrb_q : s_axi_wstrb;
    assign do_write = (aw_held | aw_hs) & (w_held | w_hs) & ~s_axi_bvalid;
    assign wr_ctrl_hit = (wr_addr == `DCF_CTRL_OFFSET);
    assign wr_mapped = wr_ctrl_hit | (wr_addr == `DCF_STATUS_OFFSET)
        | (wr_addr == `DCF_DEPTH_OFFSET);

    // Channel handshakes, holding registers and the response.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DCF_RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (aw_hs) begin
                awaddr_q <= s_axi_awaddr;
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_hs) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
            end
            if (b_hs) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Control register; only byte lane 0 carries a field.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_clear <= `DCF_CTRL_RESET;
        end else if (do_write && wr_ctrl_hit && wr_strb[0]) begin
            ctrl_clear <= wr_data[`DCF_CTRL_CLEAR_BIT];
        end
    end

    // ======================================================================
    // AXI4-Lite read path
    // ======================================================================
    logic ar_hs;
    logic r_hs;
    dcf_pkg::dcf_flags_t flags_now;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;
    logic [31:0] depth_word;
    logic [31:0] rd_word;
    logic rd_mapped;

    assign ar_hs = s_axi_arvalid & s_axi_arready;
    assign r_hs = s_axi_rvalid & s_axi_rready;
    assign flags_now.full_n = full_flag_n;
    assign flags_now.afull_n = almost_full_flag_n;
    assign flags_now.aempty_n = almost_empty_flag_n;
    assign flags_now.empty_n = empty_flag_n;

    // Read words; unused bits read as zero.
    assign ctrl_word = {31'h0000_0000, ctrl_clear};
    assign status_word = (32'(fill_now) << `DCF_STATUS_FILL_LSB)
        | (32'(flags_now) << `DCF_STATUS_FLAGS_LSB);
    assign depth_word = 32'(DEPTH);

    // Address decode; an unmapped address reads zero with an error.
    assign rd_mapped = (s_axi_araddr == `DCF_CTRL_OFFSET)
        | (s_axi_araddr == `DCF_STATUS_OFFSET)
        | (s_axi_araddr == `DCF_DEPTH_OFFSET);
    assign rd_word = (s_axi_araddr == `DCF_CTRL_OFFSET) ? ctrl_word
        : (s_axi_araddr == `DCF_STATUS_OFFSET) ? status_word
        : (s_axi_araddr == `DCF_DEPTH_OFFSET) ? depth_word
        : 32'h0000_0000;

    // One read under way at a time; data is captured with the address.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `DCF_RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_mapped ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
        end else if (r_hs) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule : dcf_fifo

`default_nettype wire

// ===== dv/dcf_checker.sv
// Concurrent checks on the ports of the status-flag FIFO.
`timescale 1ns/1ps
`default_nettype none
`include "dcf_cfg.svh"

module dcf_checker #(
    parameter int DEPTH = `DCF_DEPTH_DEFAULT
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // Port pins.
    input wire logic write_clk,
    input wire logic read_clk,
    input wire logic output_enable_n,
    input wire logic reset_in_n,
    input wire logic [`DCF_DATA_W-1:0] read_data_out,
    input wire logic read_data_oe,
    // Status flags.
    input wire logic full_flag_n,
    input wire logic almost_full_flag_n,
    input wire logic almost_empty_flag_n,
    input wire logic empty_flag_n,
    // Read address and data handshakes.
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    // ======================================================================
    // Age of the last port clock rise
    // ======================================================================
    // Ages saturate, so a long idle stretch never wraps back into the window.
    logic w_prev;
    logic r_prev;
    logic [3:0] w_age;
    logic [3:0] r_age;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            w_prev <= 1'b0;
            r_prev <= 1'b0;
            w_age <= 4'hF;
            r_age <= 4'hF;
        end else begin
            w_prev <= write_clk;
            r_prev <= read_clk;
            w_age <= (write_clk && !w_prev) ? 4'h0 : w_age + {3'h0, w_age != 4'hF};
            r_age <= (read_clk && !r_prev) ? 4'h0 : r_age + {3'h0, r_age != 4'hF};
        end
    end

    default clocking dcf_cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    // ======================================================================
    // Assertions
    // ======================================================================
    a_full_wr_edge: assert property ($fell(full_flag_n) |-> w_age inside {[1:6]})
        else $error("full fell off a write edge");
    a_afull_wr_edge: assert property ($fell(almost_full_flag_n) |-> w_age inside {[1:6]})
        else $error("almost full fell off a write edge");
    a_empty_rd_edge: assert property ($rose(empty_flag_n) |-> r_age inside {[1:6]})
        else $error("empty rose off a read edge");
    a_aempty_rd_edge: assert property ($rose(almost_empty_flag_n) |-> r_age inside {[1:6]})
        else $error("almost empty rose off a read edge");
    a_full_band: assert property (!full_flag_n |-> !almost_full_flag_n)
        else $error("full without almost full");
    a_empty_band: assert property (!empty_flag_n |-> !almost_empty_flag_n)
        else $error("empty without almost empty");
    a_reset_clears: assert property ((!reset_in_n)[*5] |-> read_data_out == 8'h00 && !empty_flag_n && full_flag_n)
        else $error("reset pin did not clear");
    a_oe_float: assert property (output_enable_n[*6] |-> !read_data_oe)
        else $error("bus driven while disabled");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read data");

    // Main scenarios reached.
    c_full: cover property ($fell(full_flag_n));
    c_empty_left: cover property ($rose(empty_flag_n));
    c_reset_pin: cover property ($rose(reset_in_n));
endmodule : dcf_checker

bind dcf_fifo dcf_checker #(.DEPTH(DEPTH)) u_dcf_checker (.sys_clk, .resetn, .write_clk,
    .read_clk, .output_enable_n, .reset_in_n, .read_data_out, .read_data_oe, .full_flag_n,
    .almost_full_flag_n, .almost_empty_flag_n, .empty_flag_n, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid);

`default_nettype wire

// ===== dv/dcf_port_model.sv
// Writer and reader logic that drives the FIFO port pins.
`timescale 1ns/1ps
`default_nettype none

module dcf_port_model (
    // Pacing clock.
    input wire logic sys_clk,
    // Write port pins.
    output var logic write_clk,
    output var logic write_en_n,
    output var logic [7:0] write_data_in,
    // Read port pins.
    output var logic read_clk,
    output var logic read_en_n
);
    // Pins start idle: clocks low, enables off.
    initial begin
        write_clk = 1'b0;
        write_en_n = 1'b1;
        write_data_in = 8'h00;
        read_clk = 1'b0;
        read_en_n = 1'b1;
    end

    // One write period: controls lead and trail the rise by four cycles.
    // Idle data shows the inverse of whatever the data pins held before.
    task automatic wcycle(input logic en_n, input logic [7:0] d);
        @(posedge sys_clk);
        write_en_n <= en_n;
        write_data_in <= en_n ? ~write_data_in : d;
        repeat (4) @(posedge sys_clk);
        write_clk <= 1'b1;
        repeat (4) @(posedge sys_clk);
        write_clk <= 1'b0;
    endtask : wcycle

    // One read period with the same spacing.
    task automatic rcycle(input logic en_n);
        @(posedge sys_clk);
        read_en_n <= en_n;
        repeat (4) @(posedge sys_clk);
        read_clk <= 1'b1;
        repeat (4) @(posedge sys_clk);
        read_clk <= 1'b0;
    endtask : rcycle
endmodule : dcf_port_model

`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the status-flag FIFO.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module tb_top;
    localparam int DEPTH = 64;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic reset_in_n = 1'b0;
    logic output_enable_n = 1'b0;
    logic write_clk, write_en_n, read_clk, read_en_n, read_data_oe;
    logic [7:0] write_data_in, read_data_out, awaddr = 8'h00, araddr = 8'h00;
    logic full_flag_n, almost_full_flag_n, almost_empty_flag_n, empty_flag_n;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 32'h0000_0000, rdata, got;
    logic [1:0] bresp, rresp;
    logic [2:0] prot = 3'h0;
    logic [3:0] wstrb = 4'hF;
    int error_cnt = 0;
    int n_tests = 0;

    always #4 sys_clk = ~sys_clk;

    // ======================================================================
    // Design, far-side model
    // ======================================================================
    dcf_fifo #(.DEPTH(DEPTH)) u_dcf_fifo (.sys_clk, .resetn, .write_clk, .write_en_n,
        .write_data_in, .read_clk, .read_en_n, .output_enable_n, .read_data_out, .read_data_oe,
        .reset_in_n, .full_flag_n, .almost_full_flag_n, .almost_empty_flag_n, .empty_flag_n,
        .s_axi_awaddr(awaddr), .s_axi_awprot(prot), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(prot), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    dcf_port_model u_dcf_port_model (.sys_clk, .write_clk, .write_en_n, .write_data_in,
        .read_clk, .read_en_n);

    // ======================================================================
    // Helpers
    // ======================================================================
    // Expected flag image for an occupancy.
    function automatic logic [3:0] exp_flags(input int occ);
        return {occ != DEPTH, occ < DEPTH - 7, occ >= 8, occ != 0};
    endfunction : exp_flags

    task automatic chk_flags(input int occ);
        `CHK("flags", exp_flags(occ), {full_flag_n, almost_full_flag_n, almost_empty_flag_n, empty_flag_n})
    endtask : chk_flags

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    task automatic timed_out();
        error_cnt++;
        $display("bus wait ran out");
        final_report();
    endtask : timed_out

    // Both write channels offered together.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (i == 64) timed_out();
        `CHK("bresp", er, bresp)
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        int i;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        d = rdata;
        if (i == 64) timed_out();
        `CHK("rresp", er, rresp)
    endtask : axi_read

    // Hang guard.
    initial begin
        repeat (90000) @(posedge sys_clk);
        timed_out();
    end

    // ======================================================================
    // Scenarios
    // ======================================================================
    initial begin
        int k;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        reset_in_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk_flags(0);
        `CHK("data", 8'h00, read_data_out)
        `CHK("oe", 1'b1, read_data_oe)
        output_enable_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        `CHK("oe", 1'b0, read_data_oe)
        output_enable_n <= 1'b0;
        $display("test reset_state done");
        // Fill, then push once more.
        for (k = 1; k <= DEPTH; k++) begin
            u_dcf_port_model.wcycle(1'b0, 8'(k));
            u_dcf_port_model.rcycle(1'b1);
            chk_flags(k);
        end
        u_dcf_port_model.wcycle(1'b0, 8'hEE);
        chk_flags(DEPTH);
        $display("test fill done");
        // Drain, then pull once more.
        for (k = 1; k <= DEPTH; k++) begin
            u_dcf_port_model.rcycle(1'b0);
            `CHK("rdata", 8'(k), read_data_out)
            u_dcf_port_model.wcycle(1'b1, 8'h00);
            chk_flags(DEPTH - k);
        end
        u_dcf_port_model.rcycle(1'b0);
        `CHK("hold", 8'(DEPTH), read_data_out)
        chk_flags(0);
        $display("test drain done");
        // Device reset, then first word latency.
        for (k = 0; k < 3; k++) u_dcf_port_model.wcycle(1'b0, 8'h5A);
        reset_in_n <= 1'b0;
        u_dcf_port_model.rcycle(1'b1);
        u_dcf_port_model.wcycle(1'b1, 8'h00);
        reset_in_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk_flags(0);
        `CHK("rdata", 8'h00, read_data_out)
        u_dcf_port_model.wcycle(1'b0, 8'hC3);
        u_dcf_port_model.rcycle(1'b0);
        u_dcf_port_model.rcycle(1'b0);
        `CHK("first", 8'hC3, read_data_out)
        $display("test device_reset done");
        // Register access.
        axi_read(8'h04, 2'b00, got);
        `CHK("status", 4'b1100, got[3:0])
        axi_read(8'h08, 2'b00, got);
        `CHK("depth", 32'(DEPTH), got)
        axi_read(8'h10, 2'b10, got);
        `CHK("unmapped", 32'h0000_0000, got)
        axi_write(8'h00, 32'h0000_0001, 2'b00);
        u_dcf_port_model.wcycle(1'b0, 8'h11);
        u_dcf_port_model.rcycle(1'b1);
        chk_flags(0);
        axi_write(8'h00, 32'h0000_0000, 2'b00);
        axi_write(8'h10, 32'h0000_0001, 2'b10);
        wstrb <= 4'h0;
        axi_write(8'h00, 32'h0000_0001, 2'b00);
        axi_read(8'h00, 2'b00, got);
        `CHK("strb", 32'h0000_0000, got)
        $display("test registers done");
        final_report();
    end
endmodule : tb_top

`default_nettype wire
